/* File: dzsec_unit.sv */
`timescale 1ns/1ps
// Behaviour
// R1: Each zone keeps a 128-bit password.
// R2: Password reads always take 16 wait states.
// R3: Each zone uses only its own settings region.
// R4: Link pointer read first from region start.
// R5: Programmed bits only go one to zero.
// R6: Top zero link bit picks block offset.
// R7: Fields sit at fixed offsets in block.
// R8: Protect flash, OTP, RAM, coprocessor, ROM. The code guards sectors, RAM, ROM and coprocessor only, with no OTP target.
// R9: Grab settings assign sectors and RAM blocks.
// R10: Secure ROM and coprocessor belong to zone one.
// R11: Other zone cannot touch a secured zone.
// R12: Fetch-only regions allow fetches only.
// R13: Zone unlocks when key equals password.
// R14: All-ones password unlocks after dummy read.
// R15: Debug guard off by low half or zeros.
// R16: Load both zones before granting any access.
module dzsec_unit
	import dzsec_pkg::*;
#(
	parameter int NSECT = 16,
	parameter int NRAM = 16
) (
	// Clock and reset.
	input wire logic MCLK,
	input wire logic ARST_N,
	// Settings memory read port.
	output logic OTP_REQ,
	output logic OTP_ZONE,
	output logic [9:0] OTP_ADDR,
	output logic [4:0] OTP_WAIT,
	input wire logic OTP_ACK,
	input wire logic [31:0] OTP_RDATA,
	// Zone key inputs.
	input wire logic [127:0] ZONE_ONE_KEY,
	input wire logic [127:0] ZONE_TWO_KEY,
	// Processor access check.
	input wire logic ACC_VALID,
	input wire logic ACC_FETCH,
	input wire logic ACC_ZONE,
	input wire logic ACC_SECURE,
	input wire logic [1:0] ACC_TGT,
	input wire logic [4:0] ACC_IDX,
	output logic ACC_GRANT,
	output logic ACC_DENY,
	// Status.
	output logic READY,
	output logic [1:0] ZONE_UNLOCKED,
	output logic [1:0] DEBUG_GUARD_ON,
	output logic [NSECT-1:0] SECT_OWNER_TWO,
	output logic [NRAM-1:0] RAM_OWNER_TWO
);

	// ==========================================================
	// Helpers
	// ==========================================================
	// Block offset from the highest zero among the used link bits.
	function automatic logic [9:0] blk_ofs(input logic [31:0] lp);
		logic [9:0] ofs;
		ofs = DZSEC_BLK_FIRST;
		for (int i = 0; i < DZSEC_LINK_USED; i++) begin
			if (!lp[i]) begin
				// Bit zero already moves the block one step past the first.
				ofs = DZSEC_BLK_FIRST + DZSEC_BLK_STEP
					+ DZSEC_BLK_STEP * 10'(i); // R6
			end
		end
		return ofs;
	endfunction : blk_ofs

	// Bit lookup in a 32-bit mask field.
	function automatic logic mbit(input logic [31:0] m, input logic [4:0] i);
		return m[i];
	endfunction : mbit

	// ==========================================================
	// Loader
	// ==========================================================
	dzsec_state_t st_q, st_d;
	logic zone_q, zone_d;
	logic [9:0] base_q, base_d;
	logic [3:0] fld_q, fld_d;
	logic req_q, req_d;
	logic [9:0] addr_q, addr_d;
	logic [4:0] wait_q, wait_d;
	logic ready_q, ready_d;
	logic [31:0] xoram_q [2], xoram_d [2];
	logic [31:0] xosect_q [2], xosect_d [2];
	logic [31:0] gram_q [2], gram_d [2];
	logic [31:0] gsect_q [2], gsect_d [2];
	logic wr_en;
	logic [3:0] rd_addr;
	logic [31:0] pw_word;

	// Passwords live in a small store, one word per slot.
	assign wr_en = (st_q == DZSEC_S_FIELD) && OTP_ACK && (fld_q >= DZSEC_FLD_PW0);
	assign rd_addr = 4'h0;

	dzsec_field_store #(.DEPTH(16)) u_store (
		.clk(MCLK),
		.arst_n(ARST_N),
		.wr_en(wr_en),
		.wr_addr({1'b0, zone_q, fld_q[2:1]}), // R1
		.wr_data(OTP_RDATA),
		.rd_addr(rd_addr),
		.rd_data()
	);

	// Password words also kept flat for comparison.
	logic [127:0] pw_q [2], pw_d [2];
	assign pw_word = OTP_RDATA;

	// Walks link pointer then fields of zone one, then zone two.
	always_comb begin
		st_d = st_q;
		zone_d = zone_q;
		base_d = base_q;
		fld_d = fld_q;
		req_d = req_q;
		addr_d = addr_q;
		wait_d = wait_q;
		ready_d = ready_q;
		xoram_d = xoram_q;
		xosect_d = xosect_q;
		gram_d = gram_q;
		gsect_d = gsect_q;
		pw_d = pw_q;
		unique case (st_q)
			DZSEC_S_LINK: begin
				req_d = 1'b1;
				addr_d = DZSEC_LINK_OFS; // R4
				wait_d = 5'(DZSEC_OTP_WAIT);
				if (req_q && OTP_ACK) begin
					base_d = blk_ofs(OTP_RDATA); // R5
					fld_d = DZSEC_FLD_XORAM;
					req_d = 1'b0;
					st_d = DZSEC_S_FIELD;
				end
			end
			DZSEC_S_FIELD: begin
				req_d = 1'b1;
				addr_d = base_q + {6'h00, fld_q}; // R7
				if (fld_q >= DZSEC_FLD_PW0) begin
					wait_d = 5'(DZSEC_PW_WAIT); // R2
				end else begin
					wait_d = 5'(DZSEC_OTP_WAIT);
				end
				if (req_q && OTP_ACK) begin
					req_d = 1'b0;
					unique case (fld_q)
						DZSEC_FLD_XORAM: xoram_d[zone_q] = OTP_RDATA;
						DZSEC_FLD_XOSECT: xosect_d[zone_q] = OTP_RDATA;
						DZSEC_FLD_GRAM: gram_d[zone_q] = OTP_RDATA;
						DZSEC_FLD_GSECT: gsect_d[zone_q] = OTP_RDATA;
						default: pw_d[zone_q][32*fld_q[2:1] +: 32] = pw_word;
					endcase
					if (fld_q == DZSEC_FLD_END) begin
						st_d = DZSEC_S_NEXT;
					end else begin
						fld_d = fld_q + DZSEC_FLD_STEP;
					end
				end
			end
			DZSEC_S_NEXT: begin
				if (zone_q == DZSEC_ZONE_ONE) begin
					zone_d = DZSEC_ZONE_TWO; // R3
					st_d = DZSEC_S_LINK;
				end else begin
					ready_d = 1'b1; // R16
					st_d = DZSEC_S_DONE;
				end
			end
			DZSEC_S_DONE: begin
				req_d = 1'b0;
			end
			default: st_d = DZSEC_S_DONE;
		endcase
	end

	// Registers the loader state.
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_q <= DZSEC_S_LINK;
			zone_q <= DZSEC_ZONE_ONE;
			base_q <= DZSEC_BLK_FIRST;
			fld_q <= DZSEC_FLD_XORAM;
			req_q <= 1'b0;
			addr_q <= DZSEC_LINK_OFS;
			wait_q <= '0;
			ready_q <= 1'b0;
			for (int z = 0; z < 2; z++) begin
				xoram_q[z] <= '0;
				xosect_q[z] <= '0;
				gram_q[z] <= '0;
				gsect_q[z] <= '0;
				pw_q[z] <= '0;
			end
		end else begin
			st_q <= st_d;
			zone_q <= zone_d;
			base_q <= base_d;
			fld_q <= fld_d;
			req_q <= req_d;
			addr_q <= addr_d;
			wait_q <= wait_d;
			ready_q <= ready_d;
			xoram_q <= xoram_d;
			xosect_q <= xosect_d;
			gram_q <= gram_d;
			gsect_q <= gsect_d;
			pw_q <= pw_d;
		end
	end

	// ==========================================================
	// Lock state and access check
	// ==========================================================
	logic [1:0] unl_q, unl_d;
	logic [1:0] guard_q, guard_d;
	logic gr_q, gr_d;
	logic dn_q, dn_d;
	logic [NSECT-1:0] so_q, so_d;
	logic [NRAM-1:0] ro_q, ro_d;

	// Unlock, guard, ownership and per-access decision.
	always_comb begin
		logic [127:0] key;
		logic owner;
		logic xo;
		logic ok;
		key = '0;
		owner = DZSEC_ZONE_ONE;
		xo = 1'b0;
		ok = 1'b0;
		for (int z = 0; z < 2; z++) begin
			key = (z == 0) ? ZONE_ONE_KEY : ZONE_TWO_KEY;
			unl_d[z] = ready_q && ((key == pw_q[z]) // R13
				|| (&pw_q[z])); // R14
			guard_d[z] = !(ready_q && ((key[63:0] == pw_q[z][63:0])
				|| (pw_q[z][63:0] == 64'h0))); // R15
		end
		for (int i = 0; i < NSECT; i++) begin
			so_d[i] = ready_q && !gsect_q[DZSEC_ZONE_TWO][i]; // R9
		end
		for (int i = 0; i < NRAM; i++) begin
			ro_d[i] = ready_q && !gram_q[DZSEC_ZONE_TWO][i]; // R9
		end
		unique case (ACC_TGT)
			DZSEC_TGT_SECT: begin
				owner = so_q[ACC_IDX[$clog2(NSECT)-1:0]];
				xo = !mbit(xosect_q[owner], ACC_IDX);
			end
			DZSEC_TGT_RAM: begin
				owner = ro_q[ACC_IDX[$clog2(NRAM)-1:0]];
				xo = !mbit(xoram_q[owner], ACC_IDX);
			end
			default: begin
				owner = DZSEC_ZONE_ONE; // R10
				xo = 1'b0;
			end
		endcase
		ok = ready_q // R16
			&& (ACC_SECURE ? (ACC_ZONE == owner) : unl_q[owner]) // R8 R11
			&& (ACC_FETCH || !xo); // R12
		gr_d = ACC_VALID && ok;
		dn_d = ACC_VALID && !ok;
	end

	// Registers lock state and access answers.
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			unl_q <= '0;
			guard_q <= '1;
			gr_q <= 1'b0;
			dn_q <= 1'b0;
			so_q <= '0;
			ro_q <= '0;
		end else begin
			unl_q <= unl_d;
			guard_q <= guard_d;
			gr_q <= gr_d;
			dn_q <= dn_d;
			so_q <= so_d;
			ro_q <= ro_d;
		end
	end

	// Outputs come straight from flip-flops.
	assign OTP_REQ = req_q;
	assign OTP_ZONE = zone_q;
	assign OTP_ADDR = addr_q;
	assign OTP_WAIT = wait_q;
	assign ACC_GRANT = gr_q;
	assign ACC_DENY = dn_q;
	assign READY = ready_q;
	assign ZONE_UNLOCKED = unl_q;
	assign DEBUG_GUARD_ON = guard_q;
	assign SECT_OWNER_TWO = so_q;
	assign RAM_OWNER_TWO = ro_q;

endmodule : dzsec_unit

/* File: dzsec_pkg.sv */
package dzsec_pkg;

	// ==========================================================
	// Settings region layout
	// ==========================================================
	localparam int DZSEC_OTP_AW = 10;
	localparam logic [9:0] DZSEC_LINK_OFS = 10'h000;
	localparam logic [9:0] DZSEC_BLK_STEP = 10'h010;
	localparam logic [9:0] DZSEC_BLK_FIRST = 10'h010;
	localparam logic [9:0] DZSEC_BLK_LAST = 10'h1f0;
	localparam int DZSEC_LINK_USED = 30;
	localparam logic [3:0] DZSEC_FLD_XORAM = 4'h0;
	localparam logic [3:0] DZSEC_FLD_XOSECT = 4'h2;
	localparam logic [3:0] DZSEC_FLD_GRAM = 4'h4;
	localparam logic [3:0] DZSEC_FLD_GSECT = 4'h6;
	localparam logic [3:0] DZSEC_FLD_PW0 = 4'h8;
	localparam logic [3:0] DZSEC_FLD_STEP = 4'h2;
	localparam logic [3:0] DZSEC_FLD_END = 4'he;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int DZSEC_PW_WAIT = 16;
	localparam int DZSEC_OTP_WAIT = 3;

	// ==========================================================
	// Zone and access encodings
	// ==========================================================
	localparam logic DZSEC_ZONE_ONE = 1'b0;
	localparam logic DZSEC_ZONE_TWO = 1'b1;
	localparam logic [1:0] DZSEC_TGT_SECT = 2'h0;
	localparam logic [1:0] DZSEC_TGT_RAM = 2'h1;
	localparam logic [1:0] DZSEC_TGT_ROM = 2'h2;
	localparam logic [1:0] DZSEC_TGT_FPU = 2'h3;

	typedef enum logic [2:0] {
		DZSEC_S_LINK,
		DZSEC_S_FIELD,
		DZSEC_S_NEXT,
		DZSEC_S_DONE
	} dzsec_state_t;

endpackage : dzsec_pkg

/* File: dzsec_field_store.sv */
`timescale 1ns/1ps
// Store of the four password words of each zone, read out through a register.
module dzsec_field_store
	import dzsec_pkg::*;
#(
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Write side.
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input wire logic [31:0] wr_data,
	// Read side.
	input wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic [31:0] rd_data
);

	logic [31:0] mem [DEPTH];

	// Stores settings words; the contents need no reset.
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registers the read word.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule : dzsec_field_store

/* File: dzsec_unit_chk.sv */
`timescale 1ns/1ps
// ==========================================================
// Checker for the settings loader and the access gate.
module dzsec_unit_chk
	import dzsec_pkg::*;
(
	// Clock and reset.
	input wire logic MCLK,
	input wire logic ARST_N,
	// Settings read port.
	input wire logic OTP_REQ,
	input wire logic OTP_ZONE,
	input wire logic [9:0] OTP_ADDR,
	input wire logic [4:0] OTP_WAIT,
	input wire logic OTP_ACK,
	// Access check and status.
	input wire logic ACC_VALID,
	input wire logic ACC_ZONE,
	input wire logic ACC_SECURE,
	input wire logic [1:0] ACC_TGT,
	input wire logic ACC_GRANT,
	input wire logic ACC_DENY,
	input wire logic READY,
	input wire logic [1:0] ZONE_UNLOCKED,
	input wire logic [1:0] DEBUG_GUARD_ON
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!ARST_N);
	// A read is taken on its answer; an access asked before loading ends.
	sequence otp_take;
		OTP_REQ && OTP_ACK;
	endsequence
	sequence acc_early;
		ACC_VALID && !READY;
	endsequence
	pw_wait_a: assert property (OTP_REQ |->
		OTP_WAIT == (OTP_ADDR[3] ? 5'h10 : 5'h03)) else $error("wait bad");
	link_first_a: assert property ($rose(ARST_N) |=>
		OTP_REQ && OTP_ADDR == 10'h000 && !OTP_ZONE) else $error("no link");
	zone_link_a: assert property ($rose(OTP_REQ) && OTP_ZONE &&
		!$past(OTP_ZONE, 2) |-> OTP_ADDR == 10'h000) else $error("zone");
	req_hold_a: assert property (OTP_REQ && !OTP_ACK |=>
		OTP_REQ && $stable(OTP_ADDR) && $stable(OTP_ZONE)) else $error("hold");
	read_gap_a: assert property (otp_take |=> !OTP_REQ)
		else $error("no gap");
	acc_answer_a: assert property (ACC_VALID |=> ACC_GRANT ^ ACC_DENY)
		else $error("no answer");
	early_deny_a: assert property (acc_early |=> ACC_DENY)
		else $error("early grant");
	rom_owner_a: assert property (ACC_VALID && ACC_SECURE &&
		ACC_ZONE == DZSEC_ZONE_TWO && ACC_TGT[1] |=> ACC_DENY)
		else $error("rom owner");
	lock_early_a: assert property (!READY |-> ZONE_UNLOCKED == 2'h0)
		else $error("early unlock");
	guard_early_a: assert property (!READY |-> DEBUG_GUARD_ON == 2'h3)
		else $error("early guard off");
endmodule : dzsec_unit_chk

bind dzsec_unit dzsec_unit_chk u_chk (.MCLK(MCLK), .ARST_N(ARST_N),
	.OTP_REQ(OTP_REQ), .OTP_ZONE(OTP_ZONE), .OTP_ADDR(OTP_ADDR),
	.OTP_WAIT(OTP_WAIT), .OTP_ACK(OTP_ACK), .ACC_VALID(ACC_VALID),
	.ACC_ZONE(ACC_ZONE), .ACC_SECURE(ACC_SECURE), .ACC_TGT(ACC_TGT),
	.ACC_GRANT(ACC_GRANT), .ACC_DENY(ACC_DENY), .READY(READY),
	.ZONE_UNLOCKED(ZONE_UNLOCKED), .DEBUG_GUARD_ON(DEBUG_GUARD_ON));

/* File: dzsec_otp_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Settings memory of both zones, answering after the asked wait.
module dzsec_otp_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Read port.
	input wire logic req,
	input wire logic zone,
	input wire logic [9:0] addr,
	input wire logic [4:0] wait_n,
	output logic ack,
	output logic [31:0] rdata,
	// Contents set by the bench.
	input wire logic [31:0] link_one,
	input wire logic [31:0] link_two,
	input wire logic [127:0] pw_one,
	input wire logic [127:0] pw_two
);
	logic [4:0] cnt;
	logic [9:0] base, rel;
	logic [31:0] link, data;
	logic [127:0] pw, masks;
	// Each zone reads only its own region.
	assign link = zone ? link_two : link_one;
	assign pw = zone ? pw_two : pw_one;
	assign masks = zone ? 128'hffff_fffc_ffff_fffb_ffff_fffd_ffff_ffff :
		128'hffff_ffff_ffff_ffff_ffff_ffff_ffff_fffe;
	// The highest zero below the two top bits picks the block.
	always_comb begin
		base = 10'h010;
		for (int p = 0; p < 30; p++)
			if (!link[p]) base = 10'((p + 2) * 16);
		rel = addr - base;
		data = 32'h0;
		if (addr == 10'h000) data = link;
		else if (rel < 10'h010) data = rel[3] ? pw[32*rel[2:1] +: 32] :
			masks[32*rel[2:1] +: 32];
	end
	// Answer after the wait; between answers the data wanders.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 5'h00;
			ack <= 1'h0;
			rdata <= 32'h0;
		end else begin
			ack <= 1'h0;
			rdata <= ~rdata;
			if (req && !ack) begin
				cnt <= cnt + 5'h01;
				if (cnt == wait_n) begin
					cnt <= 5'h00;
					ack <= 1'h1;
					rdata <= data;
				end
			end
		end
	end
endmodule : dzsec_otp_model

/* File: dzsec_unit_bench.sv */
`timescale 1ns/1ps
// ==========================================================
// Bench: loads both zones, then checks status and access answers.
module dzsec_unit_bench
	import dzsec_pkg::*;
;
	logic mclk, arst_n, req, zone, ack, av, af, az, asec, grant, deny, rdy;
	logic [9:0] addr;
	logic [4:0] wt, idx;
	logic [1:0] tgt, unl, grd;
	logic [31:0] rdata, l1, l2;
	logic [127:0] k1, k2, p1, p2;
	logic [15:0] so, ro;
	int err_count, n_tests;
	localparam logic [127:0] PW = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
	dzsec_unit u_dut (.MCLK(mclk), .ARST_N(arst_n), .OTP_REQ(req),
		.OTP_ZONE(zone), .OTP_ADDR(addr), .OTP_WAIT(wt), .OTP_ACK(ack),
		.OTP_RDATA(rdata), .ZONE_ONE_KEY(k1), .ZONE_TWO_KEY(k2),
		.ACC_VALID(av), .ACC_FETCH(af), .ACC_ZONE(az), .ACC_SECURE(asec),
		.ACC_TGT(tgt), .ACC_IDX(idx), .ACC_GRANT(grant), .ACC_DENY(deny),
		.READY(rdy), .ZONE_UNLOCKED(unl), .DEBUG_GUARD_ON(grd),
		.SECT_OWNER_TWO(so), .RAM_OWNER_TWO(ro));
	dzsec_otp_model u_otp (.clk(mclk), .arst_n(arst_n), .req(req),
		.zone(zone), .addr(addr), .wait_n(wt), .ack(ack), .rdata(rdata),
		.link_one(l1), .link_two(l2), .pw_one(p1), .pw_two(p2));
	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	// One access; the valid stays up so calls run back to back.
	task automatic acc(input logic f, z, s, input logic [1:0] t,
		input logic [4:0] i, input logic g);
		av = 1'h1;
		af = f;
		az = z;
		asec = s;
		tgt = t;
		idx = i;
		@(negedge mclk);
		chk("grant", grant, g);
		chk("deny", deny, !g);
	endtask : acc
	// Reset with new contents and keys, then wait for loading.
	task automatic boot(input logic [31:0] a, b,
		input logic [127:0] c, d, e, g);
		arst_n = 1'h0;
		l1 = a;
		l2 = b;
		p1 = c;
		p2 = d;
		k1 = e;
		k2 = g;
		repeat (16) @(negedge mclk);
		chk("guard", grd, 2'h3);
		arst_n = 1'h1;
		acc(1'h0, 1'h0, 1'h0, DZSEC_TGT_SECT, 5'h05, 1'h0);
		av = 1'h0;
		for (int i = 0; i < 1000 && rdy !== 1'h1; i++)
			@(negedge mclk);
		if (rdy !== 1'h1) begin
			err_count++;
			wrap_up();
		end
		repeat (2) @(negedge mclk);
	endtask : boot
	// Free-running clock.
	initial begin
		mclk = 1'h0;
		forever #2.5 mclk = ~mclk;
	end
	// Two boots with different settings, each followed by accesses.
	initial begin
		err_count = 0;
		n_tests = 0;
		{av, af, az, asec, tgt, idx} = 11'h000;
		boot(32'hffff_fff0, 32'h8fff_ffff, {4{32'hffff_ffff}}, PW,
			128'h0, {~PW[127:64], PW[63:0]});
		chk("unlocked", unl, 2'h1);
		chk("guard", grd, 2'h1);
		chk("sect owner", so, 16'h0003);
		chk("ram owner", ro, 16'h0004);
		acc(1'h0, 1'h0, 1'h0, DZSEC_TGT_SECT, 5'h05, 1'h1);
		acc(1'h0, 1'h0, 1'h0, DZSEC_TGT_SECT, 5'h00, 1'h0);
		acc(1'h1, 1'h1, 1'h1, DZSEC_TGT_SECT, 5'h01, 1'h1);
		acc(1'h0, 1'h1, 1'h1, DZSEC_TGT_SECT, 5'h01, 1'h0);
		acc(1'h0, 1'h0, 1'h1, DZSEC_TGT_SECT, 5'h00, 1'h0);
		acc(1'h0, 1'h0, 1'h0, DZSEC_TGT_RAM, 5'h00, 1'h0);
		acc(1'h1, 1'h0, 1'h0, DZSEC_TGT_RAM, 5'h00, 1'h1);
		acc(1'h0, 1'h0, 1'h0, DZSEC_TGT_RAM, 5'h02, 1'h0);
		acc(1'h0, 1'h1, 1'h1, DZSEC_TGT_ROM, 5'h00, 1'h0);
		acc(1'h0, 1'h0, 1'h1, DZSEC_TGT_FPU, 5'h00, 1'h1);
		av = 1'h0;
		$display("test one done");
		boot(32'hffff_ffff, 32'hffff_ffff, {64'h1111_2222_3333_4444, 64'h0},
			PW, 128'h5, PW);
		chk("unlocked", unl, 2'h2);
		chk("guard", grd, 2'h0);
		acc(1'h0, 1'h0, 1'h0, DZSEC_TGT_SECT, 5'h00, 1'h1);
		acc(1'h0, 1'h0, 1'h0, DZSEC_TGT_SECT, 5'h05, 1'h0);
		av = 1'h0;
		$display("test two done");
		wrap_up();
	end
endmodule : dzsec_unit_bench
